// ==== rtl/otp_security_config.sv ====
// one-time-programmable store of a tile with its security configuration word
// assumes: apb master on CLOCK_I, processor held until the boot copy ends,
// debug-sourced bus transfers flagged by DBG_ACCESS_I
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "otp_consts.svh"

module otp_security_config (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [`APB_AW-1:0] PADDR_I,
  input wire logic [`OTP_DW-1:0] PWDATA_I,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [`OTP_DW-1:0] PRDATA_O,
  // marks the current bus transfer as coming from the debug port
  input wire logic DBG_ACCESS_I,
  // security controls towards the tile
  output logic DBG_TILE_BLOCK_O,
  output logic LINK_BLOCK_O,
  output logic BOOT_FROM_OTP_O,
  output logic REDUNDANT_EN_O,
  output logic DBG_OTP_BLOCK_O,
  output logic DEBUG_PIN_DIS_O,
  output logic [`UID_W-1:0] USER_ID_O,
  // boot copy into sram
  output logic CPU_HOLD_O,
  output logic BOOT_VALID_O,
  output logic [`OTP_IDX_W-1:0] BOOT_ADDR_O,
  output logic [`OTP_DW-1:0] BOOT_DATA_O,
  output logic BOOT_DONE_O
);

  // ---------------------------------------------------------------
  // state and array hookup
  // ---------------------------------------------------------------
  otp_pkg::ctl_t r_reg;
  otp_pkg::ctl_t r_next;
  logic prog;
  logic [`OTP_AW-1:0] prog_addr;
  logic [`OTP_AW-1:0] rd_addr;
  logic [`OTP_DW-1:0] rd_data;
  logic setup;
  logic access;
  logic dbg_deny;
  logic out_range;
  logic sector_locked;
  logic [`OTP_SEC_W-1:0] sector;
  logic [`SEC_LOCK3-`SEC_LOCK0:0] locks;

  // 2048 rows of 32 bits plus the security row
  otp_cell_array u_array (
    .clk_i(CLOCK_I),
    .prog_i(prog),
    .prog_addr_i(prog_addr),
    .prog_data_i(r_reg.data),
    .rd_addr_i(rd_addr),
    .rd_data_o(rd_data)
  );

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  // row address layout: sector in the top two index bits
  assign sector = r_reg.addr[`OTP_IDX_W-1:`OTP_ROW_W];
  assign locks = r_reg.sec[`SEC_LOCK3:`SEC_LOCK0];
  assign sector_locked = locks[sector] | r_reg.sec[`SEC_MASTER];
  assign out_range = |r_reg.addr[`PORT16_W-1:`OTP_IDX_W];
  // debug-side transfers refused while either debug lock is set
  assign dbg_deny = DBG_ACCESS_I & (r_reg.sec[`SEC_DBG_TILE] | r_reg.sec[`SEC_DBG_OTP]);
  // no wait state: the answer is prepared in setup, so prdata is a flop
  assign setup = PSEL_I & ~PENABLE_I & ~r_reg.pready;
  assign access = PSEL_I & PENABLE_I & r_reg.pready;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    prog = 1'b0;
    prog_addr = {1'b0, r_reg.addr[`OTP_IDX_W-1:0]};
    rd_addr = `OTP_SEC_ROW;
    r_next.pready = 1'b0;
    // error flag stands only with pready, so the port needs no gate
    r_next.pslverr = 1'b0;
    r_next.pend = 1'b0;

    // bus setup: decide answer and error before the access edge
    if (setup) begin
      r_next.pready = 1'b1;
      r_next.pslverr = dbg_deny;
      r_next.prdata = '0;
      case (PADDR_I)
        `OFS_ADDR: begin
          r_next.prdata = {{(`OTP_DW-`PORT16_W){1'b0}}, r_reg.addr};
        end
        `OFS_DATA: begin
          r_next.prdata = r_reg.data;
        end
        `OFS_CTRL: begin
          r_next.prdata = {{(`OTP_DW-`CMD_W){1'b0}}, r_reg.cmd};
          // a command while the controller works would be lost
          if (PWRITE_I && r_reg.state != otp_pkg::ST_IDLE) begin
            r_next.pslverr = 1'b1;
          end
        end
        `OFS_STATUS: begin
          r_next.prdata[`ST_BUSY] = (r_reg.state != otp_pkg::ST_IDLE);
          r_next.prdata[`ST_ERR] = r_reg.err;
          r_next.prdata[`ST_LOADED] = r_reg.loaded;
          r_next.prdata[`ST_BOOTED] = r_reg.booted;
        end
        `OFS_CONFIG: begin
          r_next.prdata = r_reg.sec;
          if (PWRITE_I) begin
            r_next.pslverr = 1'b1;
          end
        end
        `OFS_RDATA: begin
          r_next.prdata = r_reg.rdat;
          if (PWRITE_I) begin
            r_next.pslverr = 1'b1;
          end
        end
        default: begin
          r_next.pslverr = 1'b1;
        end
      endcase
      if (dbg_deny) begin
        r_next.prdata = '0;
      end
    end

    // bus access: writes land only on the completing edge, never on error
    if (access && PWRITE_I && !r_reg.pslverr) begin
      case (PADDR_I)
        `OFS_ADDR: begin
          r_next.addr = PWDATA_I[`PORT16_W-1:0];
        end
        `OFS_DATA: begin
          r_next.data = PWDATA_I;
        end
        `OFS_CTRL: begin
          r_next.cmd = PWDATA_I[`CMD_W-1:0];
          if (PWDATA_I[`CMD_W-1:0] != `CMD_NONE) begin
            r_next.state = otp_pkg::ST_EXEC;
          end
        end
        `OFS_STATUS: begin
          if (PWDATA_I[`ST_ERR]) begin
            r_next.err = 1'b0;
          end
        end
        default: begin
          r_next.err = r_reg.err;
        end
      endcase
    end

    // boot copy pipeline: the array answers one cycle after the address
    r_next.boot_valid = r_reg.pend;
    r_next.boot_addr = r_reg.pend_idx;
    r_next.boot_data = rd_data;
    // release only once the last word has been handed to sram
    if (r_reg.boot_valid && r_reg.boot_addr == `OTP_LAST_ROW) begin
      r_next.booted = 1'b1;
      r_next.hold = 1'b0;
    end

    // controller; error sets come after the clear above, so a set wins
    unique case (r_reg.state)
      otp_pkg::ST_LOAD: begin
        rd_addr = `OTP_SEC_ROW;
        r_next.state = otp_pkg::ST_LOADW;
      end
      otp_pkg::ST_LOADW: begin
        // locks stay at their safe value until this edge
        r_next.sec = rd_data;
        r_next.loaded = 1'b1;
        r_next.copy_idx = '0;
        r_next.state = otp_pkg::ST_COPY;
      end
      otp_pkg::ST_COPY: begin
        rd_addr = {1'b0, r_reg.copy_idx};
        r_next.pend = 1'b1;
        r_next.pend_idx = r_reg.copy_idx;
        r_next.copy_idx = (`OTP_IDX_W)'(r_reg.copy_idx + 1'b1);
        if (r_reg.copy_idx == `OTP_LAST_ROW) begin
          r_next.state = otp_pkg::ST_IDLE;
        end
      end
      otp_pkg::ST_IDLE: begin
        // no assignment: a control write above has already moved to exec
      end
      otp_pkg::ST_EXEC: begin
        r_next.state = otp_pkg::ST_IDLE;
        case (r_reg.cmd)
          `CMD_PROG: begin
            if (sector_locked || out_range) begin
              r_next.err = 1'b1;
            end else begin
              prog = 1'b1;
            end
          end
          `CMD_READ: begin
            if (out_range) begin
              r_next.err = 1'b1;
            end else begin
              rd_addr = prog_addr;
              r_next.state = otp_pkg::ST_RDW;
            end
          end
          `CMD_PROG_SEC: begin
            // new word takes effect at the next load, live word untouched
            if (r_reg.sec[`SEC_MASTER]) begin
              r_next.err = 1'b1;
            end else begin
              prog = 1'b1;
              prog_addr = `OTP_SEC_ROW;
            end
          end
          default: begin
            r_next.err = r_reg.err;
          end
        endcase
      end
      otp_pkg::ST_RDW: begin
        r_next.rdat = rd_data;
        r_next.state = otp_pkg::ST_IDLE;
      end
      default: begin
        r_next.state = otp_pkg::ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // before the load the debug, link, pin and master locks read as set, so nothing leaks early
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      r_reg <= '0;
      r_reg.state <= otp_pkg::ST_LOAD;
      r_reg.sec <= `SEC_SAFE;
      r_reg.hold <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs, each straight from the state register
  // ---------------------------------------------------------------
  assign PREADY_O = r_reg.pready;
  assign PSLVERR_O = r_reg.pslverr;
  assign PRDATA_O = r_reg.prdata;
  assign DBG_TILE_BLOCK_O = r_reg.sec[`SEC_DBG_TILE];
  assign LINK_BLOCK_O = r_reg.sec[`SEC_LINK];
  assign BOOT_FROM_OTP_O = r_reg.sec[`SEC_SBOOT];
  assign REDUNDANT_EN_O = r_reg.sec[`SEC_REDUND];
  assign DBG_OTP_BLOCK_O = r_reg.sec[`SEC_DBG_OTP];
  assign DEBUG_PIN_DIS_O = r_reg.sec[`SEC_DBG_PIN];
  assign USER_ID_O = r_reg.sec[`SEC_UID_HI:`SEC_UID_LO];
  assign CPU_HOLD_O = r_reg.hold;
  assign BOOT_VALID_O = r_reg.boot_valid;
  assign BOOT_ADDR_O = r_reg.boot_addr;
  assign BOOT_DATA_O = r_reg.boot_data;
  assign BOOT_DONE_O = r_reg.booted;

endmodule

// ==== common/otp_consts.svh ====
// constants for the one-time-programmable store and its security word
// assumes: included by bare name from the package and from design files
`ifndef OTP_CONSTS_SVH
`define OTP_CONSTS_SVH

// ---------------------------------------------------------------
// array geometry: four sectors of 512 rows, 32 bits each
// ---------------------------------------------------------------
`define OTP_DW 32
`define OTP_ROW_W 9
`define OTP_SEC_W 2
`define OTP_IDX_W 11
`define OTP_AW 12
`define OTP_WORDS 2048
`define OTP_LAST_ROW 11'h7FF
`define OTP_SEC_ROW 12'h800

// ---------------------------------------------------------------
// processor-side port identifiers and widths
// ---------------------------------------------------------------
`define RES_ID_ADDR 24'h100200
`define RES_ID_DATA 24'h200100
`define RES_ID_CTRL 24'h100300
`define PORT16_W 16

// ---------------------------------------------------------------
// apb register offsets
// ---------------------------------------------------------------
`define APB_AW 8
`define OFS_ADDR 8'h00
`define OFS_DATA 8'h04
`define OFS_CTRL 8'h08
`define OFS_STATUS 8'h0C
`define OFS_CONFIG 8'h10
`define OFS_RDATA 8'h14

// ---------------------------------------------------------------
// control port commands and status bits
// ---------------------------------------------------------------
`define CMD_W 2
`define CMD_NONE 2'h0
`define CMD_PROG 2'h1
`define CMD_READ 2'h2
`define CMD_PROG_SEC 2'h3
`define ST_BUSY 0
`define ST_ERR 1
`define ST_LOADED 2
`define ST_BOOTED 3

// ---------------------------------------------------------------
// security word fields
// ---------------------------------------------------------------
`define SEC_DBG_TILE 0
`define SEC_LINK 1
`define SEC_SBOOT 5
`define SEC_REDUND 7
`define SEC_LOCK0 8
`define SEC_LOCK3 11
`define SEC_MASTER 12
`define SEC_DBG_OTP 13
`define SEC_DBG_PIN 14
`define SEC_GP_LO 15
`define SEC_GP_HI 21
`define SEC_UID_LO 22
`define SEC_UID_HI 31
`define UID_W 10
`define SEC_SAFE 32'h00007003

`endif

// ==== common/otp_pkg.sv ====
// types shared by the security-configuration block
// assumes: otp_consts.svh on the include path
`include "otp_consts.svh"

package otp_pkg;

  // ---------------------------------------------------------------
  // controller states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_LOAD  = 6'h01,
    ST_LOADW = 6'h02,
    ST_COPY  = 6'h04,
    ST_IDLE  = 6'h08,
    ST_EXEC  = 6'h10,
    ST_RDW   = 6'h20
  } state_t;

  // ---------------------------------------------------------------
  // whole state of the top module
  // ---------------------------------------------------------------
  typedef struct packed {
    state_t state;
    logic [`OTP_DW-1:0] sec;
    logic loaded;
    logic [`PORT16_W-1:0] addr;
    logic [`OTP_DW-1:0] data;
    logic [`CMD_W-1:0] cmd;
    logic err;
    logic [`OTP_DW-1:0] rdat;
    logic [`OTP_IDX_W-1:0] copy_idx;
    logic pend;
    logic [`OTP_IDX_W-1:0] pend_idx;
    logic boot_valid;
    logic [`OTP_IDX_W-1:0] boot_addr;
    logic [`OTP_DW-1:0] boot_data;
    logic booted;
    logic hold;
    logic pready;
    logic pslverr;
    logic [`OTP_DW-1:0] prdata;
  } ctl_t;

endpackage

// ==== rtl/otp_cell_array.sv ====
// the fuse array: 2048 data rows plus one row for the security word
// assumes: one clock, one program port and one read port from the controller
`timescale 1ns/1ps
`include "otp_consts.svh"

module otp_cell_array (
  // clock
  input wire logic clk_i,
  // program port
  input wire logic prog_i,
  input wire logic [`OTP_AW-1:0] prog_addr_i,
  input wire logic [`OTP_DW-1:0] prog_data_i,
  // read port, data one cycle after the address
  input wire logic [`OTP_AW-1:0] rd_addr_i,
  output logic [`OTP_DW-1:0] rd_data_o
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [`OTP_DW-1:0] mem [0:`OTP_WORDS];

  // unprogrammed fuses read as zero
  initial begin
    for (int i = 0; i <= `OTP_WORDS; i++) begin
      mem[i] = '0;
    end
  end

  // programming only ever adds ones, so a blown bit stays blown
  always @(posedge clk_i) begin
    if (prog_i) begin
      mem[prog_addr_i] <= mem[prog_addr_i] | prog_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule

// ==== tb/otp_sec_assertions.sv ====
// concurrent checks on the ports of the security-config block
// assumes: bound onto otp_security_config, otp_consts.svh on the include path
`timescale 1ns/1ps
`include "otp_consts.svh"

module otp_sec_checker (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  // apb side
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [`APB_AW-1:0] PADDR_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [`OTP_DW-1:0] PRDATA_O,
  input wire logic DBG_ACCESS_I,
  // security and boot outputs
  input wire logic DBG_TILE_BLOCK_O,
  input wire logic LINK_BLOCK_O,
  input wire logic BOOT_FROM_OTP_O,
  input wire logic REDUNDANT_EN_O,
  input wire logic DBG_OTP_BLOCK_O,
  input wire logic DEBUG_PIN_DIS_O,
  input wire logic [`UID_W-1:0] USER_ID_O,
  input wire logic CPU_HOLD_O,
  input wire logic BOOT_VALID_O,
  input wire logic [`OTP_IDX_W-1:0] BOOT_ADDR_O,
  input wire logic BOOT_DONE_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  // helpers: end of a debug transfer, end of a clean config read
  wire dbg_end = PSEL_I && PENABLE_I && PREADY_O && DBG_ACCESS_I;
  wire cfg_rd = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && !PSLVERR_O && PADDR_I == `OFS_CONFIG;
  wire [15:0] sec_outs = {DBG_TILE_BLOCK_O, LINK_BLOCK_O, BOOT_FROM_OTP_O, REDUNDANT_EN_O, DBG_OTP_BLOCK_O,
    DEBUG_PIN_DIS_O, USER_ID_O};
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // decision taken at the setup edge, so the word one cycle back counts
  a_dbg_tile: assert property (dbg_end && $past(DBG_TILE_BLOCK_O) |-> PSLVERR_O && PRDATA_O == 32'h0)
    else $error("debug access passed while tile debug blocked");
  a_dbg_otp: assert property (dbg_end && $past(DBG_OTP_BLOCK_O) |-> PSLVERR_O && PRDATA_O == 32'h0)
    else $error("debug access passed while otp debug blocked");
  // read data was captured in setup, so compare with the word of that cycle
  a_cfg_mirror: assert property (cfg_rd |-> PRDATA_O[`SEC_LINK] == $past(LINK_BLOCK_O) &&
    PRDATA_O[`SEC_SBOOT] == $past(BOOT_FROM_OTP_O) && PRDATA_O[`SEC_REDUND] == $past(REDUNDANT_EN_O) &&
    PRDATA_O[`SEC_DBG_PIN] == $past(DEBUG_PIN_DIS_O)) else $error("security outputs differ from live word");
  a_uid_mirror: assert property (cfg_rd |-> PRDATA_O[31:22] == $past(USER_ID_O) &&
    PRDATA_O[`SEC_DBG_TILE] == $past(DBG_TILE_BLOCK_O) && PRDATA_O[`SEC_DBG_OTP] == $past(DBG_OTP_BLOCK_O))
    else $error("user id or debug blocks differ from live word");
  // safe word must show before the load, so reset is not a disable here
  a_safe_reset: assert property (disable iff (1'h0) SRST_I |=> DBG_TILE_BLOCK_O && LINK_BLOCK_O &&
    DBG_OTP_BLOCK_O && DEBUG_PIN_DIS_O && !BOOT_FROM_OTP_O && !REDUNDANT_EN_O && USER_ID_O == 10'h0 &&
    CPU_HOLD_O && !BOOT_VALID_O) else $error("outputs not safe during reset");
  a_hold_load: assert property ($fell(SRST_I) |-> CPU_HOLD_O [*3])
    else $error("processor released before load");
  a_word_step: assert property (BOOT_VALID_O && BOOT_ADDR_O != `OTP_LAST_ROW |=> BOOT_VALID_O &&
    BOOT_ADDR_O == $past(BOOT_ADDR_O) + 11'h1) else $error("boot copy not one row per cycle");
  a_copy_held: assert property (BOOT_VALID_O |-> CPU_HOLD_O && !BOOT_DONE_O)
    else $error("copy word while processor running");
  a_done_last: assert property ($rose(BOOT_DONE_O) |-> $past(BOOT_VALID_O) &&
    $past(BOOT_ADDR_O) == `OTP_LAST_ROW && !CPU_HOLD_O) else $error("done not after last row");
  a_live_fixed: assert property (!CPU_HOLD_O && $past(CPU_HOLD_O) == 1'h0 |-> $stable(sec_outs))
    else $error("live security word changed after boot");
  // main scenarios
  c_done: cover property ($rose(BOOT_DONE_O));
  c_dbg_refused: cover property (dbg_end && PSLVERR_O);
  c_cfg_set: cover property (cfg_rd && LINK_BLOCK_O);
endmodule

// ==== tb/tile_cpu_model.sv ====
// processor model: apb master for the otp ports, sram sink for the boot copy
// assumes: shares the block's clock; requests change right after rising edges
`timescale 1ns/1ps
`include "otp_consts.svh"

module tile_cpu_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb master
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [`APB_AW-1:0] paddr_o,
  output logic [`OTP_DW-1:0] pwdata_o,
  output logic dbg_o,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [`OTP_DW-1:0] prdata_i,
  // boot copy
  input wire logic boot_valid_i,
  input wire logic [`OTP_IDX_W-1:0] boot_addr_i,
  input wire logic [`OTP_DW-1:0] boot_data_i
);
  logic [`OTP_DW-1:0] sram [`OTP_WORDS];
  int words;
  int gaps;
  initial begin
    {psel_o, penable_o, pwrite_o, dbg_o} = 4'h0;
    paddr_o = 8'hFF;
    pwdata_o = 32'hA5C3A5C3;
  end
  // no back-pressure exists, so every pulse is stored and its row checked
  always @(posedge clk_i) begin
    if (rst_i) begin
      words <= 0;
      gaps <= 0;
    end else if (boot_valid_i) begin
      sram[boot_addr_i] <= boot_data_i;
      words <= words + 1;
      if (boot_addr_i != words[10:0])
        gaps <= gaps + 1;
    end
  end
  // one transfer; held until pready seen at an edge, then lines inverted
  task automatic xfer(input logic w, input logic [`APB_AW-1:0] a, input logic [`OTP_DW-1:0] d,
      input logic dg, output logic [`OTP_DW-1:0] rd, output logic err, output logic ok);
    int n;
    @(posedge clk_i);
    psel_o <= 1'h1;
    penable_o <= 1'h0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    dbg_o <= dg;
    @(posedge clk_i);
    penable_o <= 1'h1;
    ok = 1'h0;
    for (n = 0; n < 16 && ok !== 1'h1; n++) begin
      @(posedge clk_i);
      ok = pready_i;
    end
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'h0;
    penable_o <= 1'h0;
    paddr_o <= ~a;
    pwdata_o <= ~d;
    dbg_o <= ~dg;
  endtask
endmodule

// ==== tb/tb.sv ====
// top-level bench: three boots, programming, locks, debug gating
// assumes: design, checker and processor model compiled before this file
`timescale 1ns/1ps
`include "otp_consts.svh"

module tb;
  logic clk, rst, er, ok, cerr;
  logic [31:0] rd, sec, d;
  logic [15:0] row [4];
  logic [31:0] val [4];
  int bad_count, n_checks;
  wire psel, pen, pwr, pready, pslverr, dbg, dtile, link, sboot, redund, dotp, pindis, hold, bvalid, bdone;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata, bdata;
  wire [9:0] uid;
  wire [10:0] baddr;
  otp_security_config otp_security_config_inst (.CLOCK_I(clk), .SRST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PRDATA_O(prdata), .DBG_ACCESS_I(dbg), .DBG_TILE_BLOCK_O(dtile),
    .LINK_BLOCK_O(link), .BOOT_FROM_OTP_O(sboot), .REDUNDANT_EN_O(redund), .DBG_OTP_BLOCK_O(dotp),
    .DEBUG_PIN_DIS_O(pindis), .USER_ID_O(uid), .CPU_HOLD_O(hold), .BOOT_VALID_O(bvalid),
    .BOOT_ADDR_O(baddr), .BOOT_DATA_O(bdata), .BOOT_DONE_O(bdone));
  tile_cpu_model tile_cpu_model_inst (.clk_i(clk), .rst_i(rst), .psel_o(psel), .penable_o(pen),
    .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwdata), .dbg_o(dbg), .pready_i(pready),
    .pslverr_i(pslverr), .prdata_i(prdata), .boot_valid_i(bvalid), .boot_addr_i(baddr), .boot_data_i(bdata));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // expectations, compare and bus tasks
  // ---------------------------------------------------------------
  function automatic logic prog_err(input logic [31:0] s, input int k);
    return s[`SEC_MASTER] | s[`SEC_LOCK0 + k];
  endfunction
  function automatic logic [31:0] sec_word(input logic [9:0] u, input logic [6:0] g);
    return {u, g, 15'h42A2}; // debug pin, lock 1, redundant, secure boot, link
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] dd, input logic dg);
    tile_cpu_model_inst.xfer(w, a, dd, dg, rd, er, ok);
    if (ok !== 1'h1) begin
      bad_count++;
      close_out();
    end
  endtask
  // command through the three ports, poll busy, keep and clear the sticky error
  task automatic cmd(input logic [15:0] r, input logic [31:0] dd, input logic [1:0] c);
    int n;
    acc(1'h1, `OFS_ADDR, {16'h0, r}, 1'h0);
    acc(1'h1, `OFS_DATA, dd, 1'h0);
    acc(1'h1, `OFS_CTRL, {30'h0, c}, 1'h0);
    rd = 32'h1;
    for (n = 0; n < 8 && rd[`ST_BUSY] !== 1'h0; n++)
      acc(1'h0, `OFS_STATUS, 32'h0, 1'h0);
    if (rd[`ST_BUSY] !== 1'h0) begin
      bad_count++;
      close_out();
    end
    cerr = rd[`ST_ERR];
    acc(1'h1, `OFS_STATUS, 32'h2, 1'h0);
  endtask
  task automatic rd_row(input logic [15:0] r);
    cmd(r, 32'h0, `CMD_READ);
    acc(1'h0, `OFS_RDATA, 32'h0, 1'h0);
  endtask
  // reset, try a command while the security word loads, wait for the copy to end
  task automatic boot();
    int n;
    rst <= 1'h1;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    acc(1'h1, `OFS_CTRL, 32'h1, 1'h0);
    chk("ctrl while busy", 1, er);
    for (n = 0; n < 3000 && bdone !== 1'h1; n++)
      @(posedge clk);
    chk("boot done", 1, bdone);
    if (bdone !== 1'h1)
      close_out();
    chk("cpu hold", 0, hold);
    chk("words copied", 2048, tile_cpu_model_inst.words);
    chk("row gaps", 0, tile_cpu_model_inst.gaps);
  endtask
  // program each sector under the live locks, then the security row
  task automatic lock_pass();
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      cmd(row[k], d, `CMD_PROG);
      chk("lock err", prog_err(sec, k), cerr);
      if (!prog_err(sec, k))
        val[k] |= d;
      rd_row(row[k]);
      chk("row after lock", val[k], rd);
    end
    cmd({4'h0, `OTP_SEC_ROW}, 32'h3001, `CMD_PROG_SEC);
    chk("sec row err", sec[`SEC_MASTER], cerr);
    acc(1'h0, `OFS_CONFIG, 32'h0, 1'h0);
    chk("live word", sec, rd);
    if (!sec[`SEC_MASTER])
      sec |= 32'h3001;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h7E059EC5));
    rst = 1'h1;
    bad_count = 0;
    n_checks = 0;
    boot();
    for (int k = 0; k < 4; k++) begin
      row[k] = {5'h0, k[1:0], 9'($urandom)};
      val[k] = $urandom;
      cmd(row[k], val[k], `CMD_PROG);
      chk("prog err", 0, cerr);
      d = $urandom;
      cmd(row[k], d, `CMD_PROG);
      val[k] |= d;
      rd_row(row[k]);
      chk("row", val[k], rd);
    end
    cmd(16'h0800, 32'h1, `CMD_PROG);
    chk("range prog", 1, cerr);
    rd_row(16'h0800);
    chk("range read", 1, cerr);
    acc(1'h0, 8'h20, 32'h0, 1'h0);
    chk("unmapped", 1, er);
    acc(1'h1, `OFS_CONFIG, 32'hFFFFFFFF, 1'h0);
    chk("config write", 1, er);
    acc(1'h0, `OFS_CONFIG, 32'h0, 1'h1);
    chk("debug read open", 0, er);
    chk("blank word", 0, rd);
    sec = sec_word(10'($urandom), 7'($urandom));
    cmd({4'h0, `OTP_SEC_ROW}, sec, `CMD_PROG_SEC);
    acc(1'h0, `OFS_CONFIG, 32'h0, 1'h0);
    chk("word before reset", 0, rd);
    boot();
    chk("link block", 1, link);
    chk("secure boot", 1, sboot);
    chk("redundant", 1, redund);
    chk("pin disable", 1, pindis);
    chk("user id", sec[31:22], uid);
    chk("tile debug", 0, dtile);
    for (int k = 0; k < 4; k++)
      chk("sram copy", val[k], tile_cpu_model_inst.sram[row[k][10:0]]);
    lock_pass();
    boot();
    chk("tile debug", 1, dtile);
    chk("otp debug", 1, dotp);
    lock_pass();
    acc(1'h0, `OFS_CONFIG, 32'h0, 1'h1);
    chk("debug read err", 1, er);
    chk("debug read data", 0, rd);
    acc(1'h1, `OFS_DATA, 32'h5A5A0000, 1'h1);
    chk("debug write err", 1, er);
    close_out();
  end
endmodule

bind otp_security_config otp_sec_checker otp_sec_checker_inst (.*);
